// *** hw/eds_diag_bank.sv ***
// Diagnostic and identification attribute bank of the absolute encoder
`timescale 1ns/1ps
`default_nettype none
module eds_diag_bank #(
    parameter logic [15:0] APP_FW_MAJOR = 16'h0001,
    parameter logic [15:0] APP_FW_MINOR = 16'h0000,
    parameter logic [15:0] HW_MAJOR     = 16'h0001,
    parameter logic [15:0] HW_MINOR     = 16'h0000,
    parameter logic [7:0]  NET_FW_MAJOR = 8'h01,
    parameter logic [7:0]  NET_FW_MINOR = 8'h00,
    parameter logic [7:0]  NET_FW_BUILD = 8'h00,
    parameter logic [31:0] OFFSET_MAX   = 32'hffff_ffff,
    parameter int          NUM_PWR      = eds_pkg::NUM_PARAM_WR
) (
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    input  wire logic               flash_fault,
    input  wire logic               fault_clear,
    input  wire logic [NUM_PWR-1:0] param_wr,
    input  wire logic [NUM_PWR-1:0] param_bad,
    input  wire logic               preset_apply,
    input  wire logic [31:0]        cur_position,
    input  wire logic               restore_service,
    input  wire logic [7:0]         cmd_byte,
    input  wire logic               attr_rd_req,
    input  wire logic [7:0]         attr_id,
    output logic                    attr_rd_valid,
    output logic                    attr_rd_err,
    output logic [31:0]             attr_rd_data,
    output logic [31:0]             offset_value,
    output logic                    fault_active,
    output logic                    warning_active,
    output logic                    position_valid
);
    logic        flash_err;
    logic        flash_clr;
    logic        cmd_restore_prev_r;
    logic        restore_rise;
    logic        defaults;
    logic [15:0] fault_word;
    logic [15:0] warn_word;
    logic [15:0] bad_list;
    logic [eds_pkg::NUM_BAD-1:0] bad_bits;
    logic [eds_pkg::NUM_BAD-1:0] bad_wr;
    logic [eds_pkg::NUM_BAD-1:0] bad_val;
    logic        offset_bad;
    logic [31:0] offset_r;
    logic [31:0] offset_nxt;
    logic [31:0] app_fw;
    logic [31:0] elec_rev;
    logic [31:0] net_fw;

    // Attribute identifiers that this bank answers
    function automatic logic attr_known(input logic [7:0] id);
        case (id)
            eds_pkg::ATTR_FAULT_WORD,
            eds_pkg::ATTR_FAULT_MASK,
            eds_pkg::ATTR_FAULT_FLAG,
            eds_pkg::ATTR_WARN_WORD,
            eds_pkg::ATTR_WARN_MASK,
            eds_pkg::ATTR_WARN_FLAG,
            eds_pkg::ATTR_POWERED_TIME,
            eds_pkg::ATTR_PRESET_SHIFT,
            eds_pkg::ATTR_APP_FW,
            eds_pkg::ATTR_ELEC_REV,
            eds_pkg::ATTR_NET_FW,
            eds_pkg::ATTR_BAD_LIST: attr_known = 1'b1;
            default:                attr_known = 1'b0;
        endcase
    endfunction : attr_known

    // Memory fault: cleared only once the detector has dropped
    assign flash_clr = fault_clear & ~flash_fault;

    eds_sticky_bit u_flash_err (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .set     (flash_fault),
        .clr     (flash_clr),
        .q       (flash_err)
    );

    // Restore defaults from the service or the command bit edge
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_restore_prev_r <= 1'b1;
        end else begin
            cmd_restore_prev_r <= cmd_byte[eds_pkg::CMD_RESTORE_BIT];
        end
    end

    assign restore_rise = cmd_byte[eds_pkg::CMD_RESTORE_BIT] & ~cmd_restore_prev_r;
    assign defaults     = restore_rise | restore_service;

    // Offset captured at preset, zeroed by defaults and by reset
    assign offset_bad = cur_position > OFFSET_MAX;

    always_comb begin
        offset_nxt = offset_r;
        if (defaults) begin
            offset_nxt = eds_pkg::OFFSET_DEFAULT;
        end else if (preset_apply) begin
            offset_nxt = cur_position;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            offset_r <= eds_pkg::OFFSET_DEFAULT;
        end else begin
            offset_r <= offset_nxt;
        end
    end

    assign offset_value = offset_r;

    // Per-parameter tolerance flags, rewritten on each write
    assign bad_wr  = {preset_apply, param_wr};
    assign bad_val = {offset_bad, param_bad};

    genvar gi;
    generate
        for (gi = 0; gi < eds_pkg::NUM_BAD; gi++) begin : g_bad
            eds_param_check u_chk (
                .ref_clk  (ref_clk),
                .rstn     (rstn),
                .defaults (defaults),
                .wr       (bad_wr[gi]),
                .bad      (bad_val[gi]),
                .q        (bad_bits[gi])
            );
        end
    endgenerate

    // Status words, masked so unused bits stay zero
    always_comb begin
        fault_word = '0;
        fault_word[eds_pkg::FAULT_FLASH_BIT] = flash_err;
        fault_word[eds_pkg::FAULT_DIAG_BIT] =
            |fault_word[eds_pkg::FAULT_VENDOR_HI:eds_pkg::FAULT_VENDOR_LO];
        fault_word = fault_word & eds_pkg::FAULT_SUPPORTED;
    end

    always_comb begin
        bad_list = '0;
        bad_list[eds_pkg::NUM_BAD-1:0] = bad_bits;
        bad_list = bad_list & eds_pkg::BAD_LIST_USED;
        warn_word = '0;
        warn_word[eds_pkg::WARN_PARAM_BIT] = |bad_list;
        warn_word = warn_word & eds_pkg::WARN_SUPPORTED;
    end

    assign fault_active   = |fault_word;
    assign warning_active = |warn_word;
    // Warnings never gate the position, only faults do
    assign position_valid = ~fault_active;

    // Identification words
    assign app_fw   = {APP_FW_MAJOR, APP_FW_MINOR};
    assign elec_rev = {HW_MAJOR, HW_MINOR};
    assign net_fw   = {eds_pkg::NET_FW_PAD, NET_FW_MAJOR, NET_FW_MINOR, NET_FW_BUILD};

    // Attribute read: one cycle from request to answer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            attr_rd_valid <= 1'b0;
            attr_rd_err   <= 1'b0;
        end else begin
            attr_rd_valid <= attr_rd_req;
            attr_rd_err   <= attr_rd_req & ~attr_known(attr_id);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            attr_rd_data <= '0;
        end else if (attr_rd_req) begin
            case (attr_id)
                eds_pkg::ATTR_FAULT_WORD:   attr_rd_data <= {16'h0000, fault_word};
                eds_pkg::ATTR_FAULT_MASK:   attr_rd_data <= {16'h0000, eds_pkg::FAULT_SUPPORTED};
                eds_pkg::ATTR_FAULT_FLAG:   attr_rd_data <= {31'h0000_0000, fault_active};
                eds_pkg::ATTR_WARN_WORD:    attr_rd_data <= {16'h0000, warn_word};
                eds_pkg::ATTR_WARN_MASK:    attr_rd_data <= {16'h0000, eds_pkg::WARN_SUPPORTED};
                eds_pkg::ATTR_WARN_FLAG:    attr_rd_data <= {31'h0000_0000, warning_active};
                eds_pkg::ATTR_POWERED_TIME: attr_rd_data <= eds_pkg::POWERED_TIME_VALUE;
                eds_pkg::ATTR_PRESET_SHIFT: attr_rd_data <= offset_r;
                eds_pkg::ATTR_APP_FW:       attr_rd_data <= app_fw;
                eds_pkg::ATTR_ELEC_REV:     attr_rd_data <= elec_rev;
                eds_pkg::ATTR_NET_FW:       attr_rd_data <= net_fw;
                eds_pkg::ATTR_BAD_LIST:     attr_rd_data <= {16'h0000, bad_list};
                default:                    attr_rd_data <= '0;
            endcase
        end
    end

    // Checks

    property p_fault_set;
        @(posedge ref_clk) disable iff (!rstn)
        flash_fault |=> fault_word[eds_pkg::FAULT_FLASH_BIT] && fault_active;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault bit not set");

    property p_fault_hold;
        @(posedge ref_clk) disable iff (!rstn)
        flash_err && !(fault_clear && !flash_fault) |=> flash_err;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault bit lost");

    property p_fault_clear;
        @(posedge ref_clk) disable iff (!rstn)
        fault_clear && !flash_fault |=> !fault_active && position_valid;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

    property p_fault_sum;
        @(posedge ref_clk) disable iff (!rstn)
        fault_active == flash_err;
    endproperty
    a_fault_sum: assert property (p_fault_sum) else $error("fault flag wrong");

    property p_diag;
        @(posedge ref_clk) disable iff (!rstn)
        fault_word[eds_pkg::FAULT_DIAG_BIT] == fault_word[eds_pkg::FAULT_FLASH_BIT];
    endproperty
    a_diag: assert property (p_diag) else $error("diag bit mismatch");

    property p_unused;
        @(posedge ref_clk) disable iff (!rstn)
        (fault_word & 16'hefff & 16'hfffd) == 16'h0000 &&
        (warn_word & 16'hdfff) == 16'h0000 && bad_list[15:4] == 12'h000;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");

    property p_mask_rd;
        @(posedge ref_clk) disable iff (!rstn)
        attr_rd_req && attr_id == eds_pkg::ATTR_FAULT_MASK |=> attr_rd_data == 32'h0000_1002;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("fault mask read wrong");

    property p_wmask_rd;
        @(posedge ref_clk) disable iff (!rstn)
        attr_rd_req && attr_id == eds_pkg::ATTR_WARN_MASK |=> attr_rd_data == 32'h0000_2000;
    endproperty
    a_wmask_rd: assert property (p_wmask_rd) else $error("warn mask read wrong");

    property p_warn_pos;
        @(posedge ref_clk) disable iff (!rstn)
        warning_active && !flash_err |-> position_valid;
    endproperty
    a_warn_pos: assert property (p_warn_pos) else $error("warning blocks position");

    property p_warn_clr;
        @(posedge ref_clk) disable iff (!rstn)
        param_wr == 3'b001 && !param_bad[0] && !preset_apply && !defaults
            |=> !bad_list[eds_pkg::BAD_SPAN_BIT];
    endproperty
    a_warn_clr: assert property (p_warn_clr) else $error("warning not self-cleared");

    property p_warn_sum;
        @(posedge ref_clk) disable iff (!rstn)
        warning_active == (|bad_bits) && warn_word[eds_pkg::WARN_PARAM_BIT] == warning_active;
    endproperty
    a_warn_sum: assert property (p_warn_sum) else $error("warning flag wrong");

    property p_param_bad;
        @(posedge ref_clk) disable iff (!rstn)
        param_wr[1] && param_bad[1] && !defaults |=> warning_active && bad_list[eds_pkg::BAD_RANGE_BIT];
    endproperty
    a_param_bad: assert property (p_param_bad) else $error("param error not flagged");

    property p_optime;
        @(posedge ref_clk) disable iff (!rstn)
        attr_rd_req && attr_id == eds_pkg::ATTR_POWERED_TIME |=> attr_rd_data == 32'h0000_0000;
    endproperty
    a_optime: assert property (p_optime) else $error("operating time nonzero");

    property p_offset_cap;
        @(posedge ref_clk) disable iff (!rstn)
        preset_apply && !defaults |=> offset_value == $past(cur_position);
    endproperty
    a_offset_cap: assert property (p_offset_cap) else $error("offset not captured");

    property p_offset_hold;
        @(posedge ref_clk) disable iff (!rstn)
        !preset_apply && !defaults |=> $stable(offset_value);
    endproperty
    a_offset_hold: assert property (p_offset_hold) else $error("offset changed");

    property p_restore;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(cmd_byte[eds_pkg::CMD_RESTORE_BIT]) |=> offset_value == 32'h0000_0000 && bad_list == 16'h0000;
    endproperty
    a_restore: assert property (p_restore) else $error("restore not done");

    property p_offset_bad;
        @(posedge ref_clk) disable iff (!rstn)
        preset_apply && !defaults && cur_position > OFFSET_MAX |=> bad_list[eds_pkg::BAD_OFFSET_BIT];
    endproperty
    a_offset_bad: assert property (p_offset_bad) else $error("offset range not flagged");

    property p_net_fw;
        @(posedge ref_clk) disable iff (!rstn)
        attr_rd_req && attr_id == eds_pkg::ATTR_NET_FW |=> attr_rd_data[31:24] == 8'h00;
    endproperty
    a_net_fw: assert property (p_net_fw) else $error("net version pad nonzero");

    property p_rd;
        @(posedge ref_clk) disable iff (!rstn)
        attr_rd_req |=> attr_rd_valid && (attr_rd_err == !attr_known($past(attr_id)));
    endproperty
    a_rd: assert property (p_rd) else $error("read answer wrong");

endmodule : eds_diag_bank
`default_nettype wire

// *** hw/eds_pkg.sv ***
// Constants shared by the encoder diagnostic status attribute bank
//
// Functional notes
// - A fault bit goes high when its internal fault detector becomes true.
// - A fault bit stays set until cleared while its fault detector is no longer true.
// - Fault summary flag is 1 when any fault bit is active, else 0.
// - Fault bit 1 reports a general error detailed by vendor bits 12 to 15; only 12 exists.
// - Bit 12 flags corrupted or damaged nonvolatile memory; not user recoverable.
// - Supported-fault mask is read-only and reads 1002h.
// - A warning marks an out-of-tolerance parameter; it never blocks position output.
// - Each warning bit clears by itself once its parameter is back in tolerance.
// - Warning summary flag reads 1 when any warning is active, else 0.
// - Warning bit 13 sets whenever an out-of-tolerance parameter value is written.
// - Supported-warning mask is read-only and reads 2000h.
// - Operating-time word counts tenths of an hour but is not maintained.
// - Preset computes and stores the offset word; it shifts position and is read-only.
// - Offset returns to zero when factory defaults are reloaded and on reset.
// - Application firmware version: major in bits 31-16, minor in bits 15-0.
// - Hardware version is 32 bits: major upper half, minor lower half.
// - Network firmware version: zero 31-24, major 23-16, minor 15-8, build 7-0.
// - Bad-parameter list: bit0 span units, bit1 range, bit2 preset, bit3 offset.
// - Normal state returns only after every flagged parameter is rewritten in tolerance; here restore defaults also clears every flag.
// - Offset bit 3 sets when a preset yields an out-of-tolerance offset.
// - Restore defaults runs on each rising edge of command bit 7.
package eds_pkg;
    localparam logic [7:0]  ATTR_FAULT_WORD    = 8'h2c;
    localparam logic [7:0]  ATTR_FAULT_MASK    = 8'h2d;
    localparam logic [7:0]  ATTR_FAULT_FLAG    = 8'h2e;
    localparam logic [7:0]  ATTR_WARN_WORD     = 8'h2f;
    localparam logic [7:0]  ATTR_WARN_MASK     = 8'h30;
    localparam logic [7:0]  ATTR_WARN_FLAG     = 8'h31;
    localparam logic [7:0]  ATTR_POWERED_TIME  = 8'h32;
    localparam logic [7:0]  ATTR_PRESET_SHIFT  = 8'h33;
    localparam logic [7:0]  ATTR_APP_FW        = 8'h64;
    localparam logic [7:0]  ATTR_ELEC_REV      = 8'h65;
    localparam logic [7:0]  ATTR_NET_FW        = 8'h66;
    localparam logic [7:0]  ATTR_BAD_LIST      = 8'h67;

    localparam int          FAULT_DIAG_BIT     = 1;
    localparam int          FAULT_FLASH_BIT    = 12;
    localparam int          FAULT_VENDOR_LO    = 12;
    localparam int          FAULT_VENDOR_HI    = 15;
    localparam int          WARN_PARAM_BIT     = 13;
    localparam int          BAD_SPAN_BIT       = 0;
    localparam int          BAD_RANGE_BIT      = 1;
    localparam int          BAD_PRESET_BIT     = 2;
    localparam int          BAD_OFFSET_BIT     = 3;
    localparam int          NUM_BAD            = 4;
    localparam int          NUM_PARAM_WR       = 3;
    localparam int          CMD_RESTORE_BIT    = 7;

    localparam logic [15:0] FAULT_SUPPORTED    = 16'h1002;
    localparam logic [15:0] WARN_SUPPORTED     = 16'h2000;
    localparam logic [15:0] BAD_LIST_USED      = 16'h000f;
    localparam logic [7:0]  NET_FW_PAD         = 8'h00;
    localparam logic [31:0] POWERED_TIME_VALUE = 32'h0000_0000;
    localparam logic [31:0] OFFSET_DEFAULT     = 32'h0000_0000;
endpackage : eds_pkg

// *** hw/eds_sticky_bit.sv ***
// Sticky status bit whose set beats a simultaneous clear
`timescale 1ns/1ps
`default_nettype none
module eds_sticky_bit (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    logic q_nxt;

    always_comb begin
        q_nxt = set | (q & ~clr);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= 1'b0;
        end else begin
            q <= q_nxt;
        end
    end
endmodule : eds_sticky_bit
`default_nettype wire

// *** hw/eds_param_check.sv ***
// Tolerance flag of one parameter, rewritten on every write of it
`timescale 1ns/1ps
`default_nettype none
module eds_param_check (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic defaults,
    input  wire logic wr,
    input  wire logic bad,
    output logic      q
);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= 1'b0;
        end else if (defaults) begin
            q <= 1'b0;
        end else if (wr) begin
            q <= bad;
        end
    end
endmodule : eds_param_check
`default_nettype wire

// *** sim/eds_scanner_model.sv ***
// Behavioural network scanner that reads attributes of the diagnostic bank
`timescale 1ns/1ps
`default_nettype none
module eds_scanner_model (
    input  wire logic        ref_clk,
    output var  logic        attr_rd_req,
    output var  logic [7:0]  attr_id,
    input  wire logic        attr_rd_valid,
    input  wire logic        attr_rd_err,
    input  wire logic [31:0] attr_rd_data
);
    initial begin
        attr_rd_req = 1'b0;
        attr_id     = 8'h00;
    end

    // One request per call; the caller enters just after a rising edge
    task automatic read(input logic [7:0] id, output logic valid, output logic err, output logic [31:0] data);
        attr_rd_req = 1'b1;
        attr_id     = id;
        @(posedge ref_clk);
        #1;
        // Answer stands only in the cycle after the taking edge
        valid       = attr_rd_valid;
        err         = attr_rd_err;
        data        = attr_rd_data;
        attr_rd_req = 1'b0;
        // Released id lines never keep showing the last value
        attr_id     = ~id;
        // Let an edge pass so a following call never re-raises the strobe in this step
        @(posedge ref_clk);
        #1;
    endtask : read
endmodule : eds_scanner_model
`default_nettype wire

// *** sim/tb_eds_diag_bank.sv ***
// Self-checking bench for the encoder diagnostic attribute bank
`timescale 1ns/1ps
`default_nettype none
module tb_eds_diag_bank;
    localparam logic [15:0] APP_MAJ = 16'h1234;
    localparam logic [15:0] APP_MIN = 16'h5678;
    localparam logic [15:0] HW_MAJ  = 16'h9abc;
    localparam logic [15:0] HW_MIN  = 16'hdef0;
    localparam logic [7:0]  NET_MAJ = 8'ha1;
    localparam logic [7:0]  NET_MIN = 8'hb2;
    localparam logic [7:0]  NET_BLD = 8'hc3;
    localparam logic [31:0] OFS_MAX = 32'h0000_ffff;

    typedef struct packed {logic [7:0] id; logic [31:0] data; logic err;} eds_row_t;

    logic        ref_clk, rstn, flash_fault, fault_clear, preset_apply, restore_service;
    logic        attr_rd_req, attr_rd_valid, attr_rd_err, fault_active, warning_active, position_valid;
    logic [2:0]  param_wr, param_bad;
    logic [7:0]  cmd_byte, attr_id;
    logic [31:0] cur_position, attr_rd_data, offset_value;
    int          mismatches;
    int          num_checks;

    eds_row_t rows [13] = '{
        '{8'h2c, 32'h0000_0000, 1'b0},
        '{8'h2d, 32'h0000_1002, 1'b0},
        '{8'h2e, 32'h0000_0000, 1'b0},
        '{8'h2f, 32'h0000_0000, 1'b0},
        '{8'h30, 32'h0000_2000, 1'b0},
        '{8'h31, 32'h0000_0000, 1'b0},
        '{8'h32, 32'h0000_0000, 1'b0},
        '{8'h33, 32'h0000_0000, 1'b0},
        '{8'h64, {APP_MAJ, APP_MIN}, 1'b0},
        '{8'h65, {HW_MAJ, HW_MIN}, 1'b0},
        '{8'h66, {8'h00, NET_MAJ, NET_MIN, NET_BLD}, 1'b0},
        '{8'h67, 32'h0000_0000, 1'b0},
        '{8'h40, 32'h0000_0000, 1'b1}
    };

    eds_diag_bank #(
        .APP_FW_MAJOR (APP_MAJ),
        .APP_FW_MINOR (APP_MIN),
        .HW_MAJOR     (HW_MAJ),
        .HW_MINOR     (HW_MIN),
        .NET_FW_MAJOR (NET_MAJ),
        .NET_FW_MINOR (NET_MIN),
        .NET_FW_BUILD (NET_BLD),
        .OFFSET_MAX   (OFS_MAX),
        .NUM_PWR      (3)
    ) dut (
        .ref_clk         (ref_clk),
        .rstn            (rstn),
        .flash_fault     (flash_fault),
        .fault_clear     (fault_clear),
        .param_wr        (param_wr),
        .param_bad       (param_bad),
        .preset_apply    (preset_apply),
        .cur_position    (cur_position),
        .restore_service (restore_service),
        .cmd_byte        (cmd_byte),
        .attr_rd_req     (attr_rd_req),
        .attr_id         (attr_id),
        .attr_rd_valid   (attr_rd_valid),
        .attr_rd_err     (attr_rd_err),
        .attr_rd_data    (attr_rd_data),
        .offset_value    (offset_value),
        .fault_active    (fault_active),
        .warning_active  (warning_active),
        .position_valid  (position_valid)
    );

    eds_scanner_model u_scan (
        .ref_clk       (ref_clk),
        .attr_rd_req   (attr_rd_req),
        .attr_id       (attr_id),
        .attr_rd_valid (attr_rd_valid),
        .attr_rd_err   (attr_rd_err),
        .attr_rd_data  (attr_rd_data)
    );

    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic rd(input logic [7:0] id, input logic [31:0] exp, input logic exp_err);
        logic        v;
        logic        e;
        logic [31:0] d;
        u_scan.read(id, v, e, d);
        check(32'(v), 32'h1);
        check(32'(e), 32'(exp_err));
        check(d, exp);
    endtask : rd

    task automatic wr_param(input logic [2:0] w, input logic [2:0] b);
        param_wr  = w;
        param_bad = b;
        tick();
        param_wr  = 3'h0;
        param_bad = 3'h0;
    endtask : wr_param

    task automatic preset(input logic [31:0] pos);
        cur_position = pos;
        preset_apply = 1'b1;
        tick();
        preset_apply = 1'b0;
    endtask : preset

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end

    initial begin
        rstn            = 1'b0;
        flash_fault     = 1'b0;
        fault_clear     = 1'b0;
        param_wr        = 3'h0;
        param_bad       = 3'h0;
        preset_apply    = 1'b0;
        cur_position    = 32'h0;
        restore_service = 1'b0;
        cmd_byte        = 8'h00;
        mismatches      = 0;
        num_checks      = 0;
        repeat (16) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        check(32'(position_valid), 32'h1);
        for (int i = 0; i < 13; i++) begin
            rd(rows[i].id, rows[i].data, rows[i].err);
        end
        // Memory fault, a clear refused while the detector is still high
        flash_fault = 1'b1;
        tick();
        check(32'(fault_active), 32'h1);
        check(32'(position_valid), 32'h0);
        fault_clear = 1'b1;
        tick();
        fault_clear = 1'b0;
        flash_fault = 1'b0;
        rd(8'h2c, 32'h0000_1002, 1'b0);
        rd(8'h2e, 32'h0000_0001, 1'b0);
        fault_clear = 1'b1;
        tick();
        fault_clear = 1'b0;
        check(32'(fault_active), 32'h0);
        rd(8'h2c, 32'h0, 1'b0);
        // Tolerance warnings set, partly rewritten, then all cleared
        wr_param(3'b010, 3'b010);
        check(32'(warning_active), 32'h1);
        check(32'(position_valid), 32'h1);
        rd(8'h2f, 32'h0000_2000, 1'b0);
        rd(8'h67, 32'h0000_0002, 1'b0);
        wr_param(3'b101, 3'b101);
        rd(8'h67, 32'h0000_0007, 1'b0);
        wr_param(3'b010, 3'b000);
        rd(8'h67, 32'h0000_0005, 1'b0);
        check(32'(warning_active), 32'h1);
        wr_param(3'b001, 3'b000);
        rd(8'h67, 32'h0000_0004, 1'b0);
        wr_param(3'b100, 3'b000);
        check(32'(warning_active), 32'h0);
        rd(8'h2f, 32'h0, 1'b0);
        rd(8'h31, 32'h0, 1'b0);
        // Preset beyond the offset limit, then a command restore
        preset(OFS_MAX + 32'h1);
        check(offset_value, OFS_MAX + 32'h1);
        rd(8'h67, 32'h0000_0008, 1'b0);
        rd(8'h33, OFS_MAX + 32'h1, 1'b0);
        cmd_byte = 8'h80;
        tick();
        check(offset_value, 32'h0);
        rd(8'h67, 32'h0, 1'b0);
        preset(OFS_MAX);
        rd(8'h67, 32'h0, 1'b0);
        repeat (3) tick();
        check(offset_value, OFS_MAX);
        cmd_byte = 8'h00;
        tick();
        // Restore service wins over a preset in the same cycle
        restore_service = 1'b1;
        preset(32'h0000_5678);
        restore_service = 1'b0;
        check(offset_value, 32'h0);
        // Reset in mid-run clears offset and faults
        preset(32'h0000_1234);
        flash_fault = 1'b1;
        tick();
        flash_fault = 1'b0;
        rstn = 1'b0;
        tick();
        check(offset_value, 32'h0);
        check(32'(fault_active), 32'h0);
        rstn = 1'b1;
        tick();
        rd(8'h2e, 32'h0, 1'b0);
        give_verdict();
    end
endmodule : tb_eds_diag_bank
`default_nettype wire
